// File: design/clock_mode_pll_select.sv
// Clock mode control: mode pins, loop enables, clock pin and register.
//
// Local design decisions: the register address and the strobed register port.
`timescale 1ns/100ps
module clock_mode_pll_select (
    // Clock and reset.
    input wire logic core_clk,
    input wire logic nrst,
    // Mode straps and dual purpose pin.
    input wire logic mode_select_bit2,
    input wire logic mode_select_bit1,
    input wire logic mode_select_bit0,
    input wire logic pause_request_or_crystal_select,
    // Two-way clock pin.
    input wire logic clock_io_pin_in,
    output logic clock_io_pin_out,
    output logic clock_io_pin_oe_n,
    // Register port.
    input wire logic [clk_mode_pkg::ADDR_W-1:0] reg_addr,
    input wire logic [clk_mode_pkg::DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [clk_mode_pkg::DATA_W-1:0] reg_rdata,
    // Clock generator status and controls.
    output clk_mode_pkg::clock_mode_t clock_mode,
    output logic crystal_osc_en,
    output clk_mode_pkg::clk_src_t clock_source,
    output logic mult_pll_run,
    output logic phase_pll_run,
    output clk_mode_pkg::mult_t mult_factor,
    output clk_mode_pkg::phase_t phase_shift,
    output logic internal_clk,
    // Clock pause.
    output logic pause_request,
    output logic pause_acknowledge
);
    import clk_mode_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    clock_mode_t clock_mode_ff;
    logic crystal_out_pin_sel_ff;
    logic [DATA_W-1:0] fmr_ff;
    logic [DATA_W-1:0] nxt_fmr;
    logic [DATA_W-1:0] fmr_view;
    logic [DATA_W-1:0] reg_rdata_ff;
    logic crystal_osc_en_ff;
    clk_src_t clock_source_ff;
    logic mult_run_ff;
    logic phase_run_ff;
    mult_t mult_factor_ff;
    mult_t nxt_mult;
    phase_t phase_shift_ff;
    logic pin_out_ff;
    logic pin_oe_n_ff;
    logic int_clk_ff;
    logic pause_req_ff;
    logic pause_ack_ff;
    logic fmr_hit;
    logic [2:0] mode_pins;
    mode_cfg_if cfg ();

    assign mode_pins = {mode_select_bit2, mode_select_bit1, mode_select_bit0};
    assign cfg.mode = clock_mode_ff;
    assign cfg.crystal_out_pin_sel = crystal_out_pin_sel_ff;
    assign fmr_hit = (reg_addr == FMR_ADDR);

    mode_decoder u_decoder (
        .cfg (cfg)
    );

    ////////////////////////////////////////////////////////////////////////
    // Straps are caught while reset is held and kept afterwards.
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            clock_mode_ff <= clock_mode_t'(mode_pins);
            crystal_out_pin_sel_ff <= pause_request_or_crystal_select;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Frequency modification register; unusable stop and float bits read as one, reserved bit 4 as zero.
    always_comb begin
        nxt_fmr = fmr_ff;
        nxt_fmr[FMR_FR_LSB +: FR_W] = reg_wdata[FMR_FR_LSB +: FR_W];
        nxt_fmr[FMR_RSVD_BIT] = 1'b0;
        if (cfg.mult_avail) begin
            nxt_fmr[FMR_MULT_STOP_BIT] = reg_wdata[FMR_MULT_STOP_BIT];
        end
        if (cfg.phase_avail) begin
            nxt_fmr[FMR_PHASE_STOP_BIT] =
                reg_wdata[FMR_PHASE_STOP_BIT];
        end
        if (cfg.pin_can_drive) begin
            nxt_fmr[FMR_PIN_HIZ_BIT] = reg_wdata[FMR_PIN_HIZ_BIT];
        end
    end

    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            fmr_ff <= fmr_init(mode_pins);
        end else if (reg_wr && fmr_hit) begin
            fmr_ff <= nxt_fmr;
        end
    end

    always_comb begin
        fmr_view = fmr_ff;
        fmr_view[FMR_MULT_STOP_BIT] = fmr_ff[FMR_MULT_STOP_BIT] |
                                      !cfg.mult_avail;
        fmr_view[FMR_PHASE_STOP_BIT] = fmr_ff[FMR_PHASE_STOP_BIT] |
                                       !cfg.phase_avail;
        fmr_view[FMR_PIN_HIZ_BIT] = fmr_ff[FMR_PIN_HIZ_BIT] |
                                    !cfg.pin_can_drive;
        fmr_view[FMR_RSVD_BIT] = 1'b0;
    end

    // Read data stand only in the cycle after the read strobe.
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            reg_rdata_ff <= DATA_ZERO;
        end else if (reg_rd && fmr_hit) begin
            reg_rdata_ff <= fmr_view;
        end else begin
            reg_rdata_ff <= DATA_ZERO;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Loop enables, multiplication factor and phase relation.
    always_comb begin
        nxt_mult = MULT_X1;
        if (!fmr_view[FMR_MULT_STOP_BIT]) begin
            if (!fmr_view[FMR_PHASE_STOP_BIT]) begin
                nxt_mult = MULT_X4;
            end else if (fmr_ff[FR_MULT_LSB +: 2] == FR_MULT_ONE) begin
                nxt_mult = MULT_X1;
            end else if (fmr_ff[FR_MULT_LSB +: 2] == FR_MULT_TWO) begin
                nxt_mult = MULT_X2;
            end else begin
                nxt_mult = MULT_X4;
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            mult_run_ff <= 1'b0;
            phase_run_ff <= 1'b0;
            mult_factor_ff <= MULT_X1;
            phase_shift_ff <= PH_NONE;
        end else begin
            mult_run_ff <= !fmr_view[FMR_MULT_STOP_BIT];
            phase_run_ff <= !fmr_view[FMR_PHASE_STOP_BIT];
            mult_factor_ff <= nxt_mult;
            if (fmr_view[FMR_PHASE_STOP_BIT]) begin
                phase_shift_ff <= PH_NONE;
            end else begin
                phase_shift_ff <= cfg.shift;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Clock source, crystal and clock pin.
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            crystal_osc_en_ff <= 1'b0;
            clock_source_ff <= SRC_OFF;
            pin_oe_n_ff <= 1'b1;
            pin_out_ff <= 1'b0;
        end else begin
            crystal_osc_en_ff <= !cfg.pin_is_input && crystal_out_pin_sel_ff &&
                                 (cfg.src == SRC_CRYSTAL_OUT_PIN);
            clock_source_ff <= cfg.src;
            pin_oe_n_ff <= !(cfg.pin_can_drive &&
                             !fmr_view[FMR_PIN_HIZ_BIT]);
            if (cfg.pin_can_drive && !fmr_view[FMR_PIN_HIZ_BIT]) begin
                pin_out_ff <= !pin_out_ff;
            end else begin
                pin_out_ff <= 1'b0;
            end
        end
    end

    // Internal clock follows the received clock in pin-clock modes.
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            int_clk_ff <= 1'b0;
        end else if (cfg.src == SRC_CLKIO) begin
            int_clk_ff <= clock_io_pin_in;
        end else begin
            int_clk_ff <= !int_clk_ff;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Pause request passes through in pin-clock modes and is acknowledged.
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            pause_req_ff <= 1'b0;
            pause_ack_ff <= 1'b0;
        end else begin
            pause_req_ff <= cfg.pin_is_input &&
                            pause_request_or_crystal_select;
            pause_ack_ff <= pause_req_ff && cfg.pin_is_input;
        end
    end

    assign clock_mode = clock_mode_ff;
    assign reg_rdata = reg_rdata_ff;
    assign crystal_osc_en = crystal_osc_en_ff;
    assign clock_source = clock_source_ff;
    assign mult_pll_run = mult_run_ff;
    assign phase_pll_run = phase_run_ff;
    assign mult_factor = mult_factor_ff;
    assign phase_shift = phase_shift_ff;
    assign clock_io_pin_out = pin_out_ff;
    assign clock_io_pin_oe_n = pin_oe_n_ff;
    assign internal_clk = int_clk_ff;
    assign pause_request = pause_req_ff;
    assign pause_acknowledge = pause_ack_ff;

    ////////////////////////////////////////////////////////////////////////
    // Checks.
    default clocking dflt_cb @(posedge core_clk);
    endclocking
    default disable iff (!nrst);

    sequence s_hiz_write;
        reg_wr && fmr_hit && reg_wdata[FMR_PIN_HIZ_BIT] &&
            (clock_mode_ff <= MODE2);
    endsequence

    sequence s_pin_floats;
        clock_io_pin_oe_n [*2];
    endsequence

    a_mode_capture: assert property (
        disable iff (1'b0)
        !nrst |=> clock_mode == $past(mode_pins))
        else $error("mode not taken from pins during reset");

    a_mode_held: assert property (
        $past(nrst) |-> $stable(clock_mode))
        else $error("mode changed outside reset");

    a_pin_input: assert property (
        (clock_mode >= MODE3) |=> clock_io_pin_oe_n)
        else $error("clock pin driven in an input or floating mode");

    a_hiz_write: assert property (
        s_hiz_write ##1 !(reg_wr && fmr_hit) |-> ##1 s_pin_floats)
        else $error("clock pin not floated by register write");

    // A sampled nrst in the antecedent keeps an attempt that starts on the
    // last reset edge from judging outputs that are still in reset.
    a_mode0_both: assert property (
        nrst && (clock_mode == MODE0) && !fmr_ff[FMR_MULT_STOP_BIT] &&
            !fmr_ff[FMR_PHASE_STOP_BIT] |=>
            mult_pll_run && phase_pll_run && (phase_shift == PH_ALIGN))
        else $error("mode 0 loops or phase wrong");

    a_no_shift_halt: assert property (
        fmr_view[FMR_PHASE_STOP_BIT] |=> (phase_shift == PH_NONE))
        else $error("phase shift applied with phase loop halted");

    a_mode6_off: assert property (
        (clock_mode == MODE6) |=> !mult_pll_run && !phase_pll_run)
        else $error("loop running in mode 6");

    a_mult_factor: assert property (
        mult_pll_run && !phase_pll_run &&
            $past(fmr_ff[FR_MULT_LSB +: 2] == FR_MULT_TWO) &&
            $stable(fmr_ff) |-> (mult_factor == MULT_X2))
        else $error("multiplier factor not two");

    a_pause_pass: assert property (
        nrst && (clock_mode >= MODE4) && (clock_mode <= MODE6) |=>
            pause_request == $past(pause_request_or_crystal_select))
        else $error("pause request not passed in pin-clock mode");

    a_crystal_out_pin_select: assert property (
        nrst && (clock_mode <= MODE3) |=> crystal_osc_en == crystal_out_pin_sel_ff)
        else $error("crystal enable does not follow the select strap");

endmodule // clock_mode_pll_select

// File: design/clk_mode_pkg.sv
// Constants and types shared by the clock mode controller files.
package clk_mode_pkg;

    localparam int MODE_W = 3;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 8;
    localparam int FR_W = 4;

    // Pin code of each clock mode; 3'h7 is not a supported setting.
    typedef enum logic [2:0] {
        MODE0 = 3'h0,
        MODE1 = 3'h1,
        MODE2 = 3'h2,
        MODE3 = 3'h3,
        MODE4 = 3'h4,
        MODE5 = 3'h5,
        MODE6 = 3'h6,
        MODE_BAD = 3'h7
    } clock_mode_t;

    // Phase relation of the clock pin to the internal system clock.
    typedef enum logic [1:0] {
        PH_NONE = 2'h0,
        PH_ALIGN = 2'h1,
        PH_LEAD = 2'h2,
        PH_LAG = 2'h3
    } phase_t;

    // Source of the internal clock.
    typedef enum logic [1:0] {
        SRC_CRYSTAL_OUT_PIN = 2'h0,
        SRC_XIN_CLK = 2'h1,
        SRC_CLKIO = 2'h2,
        SRC_OFF = 2'h3
    } clk_src_t;

    // Multiplication factor of the multiplying loop.
    typedef enum logic [1:0] {
        MULT_X1 = 2'h0,
        MULT_X2 = 2'h1,
        MULT_X4 = 2'h2
    } mult_t;

    // Frequency modification register location and fields.
    localparam logic [ADDR_W-1:0] FMR_ADDR = 8'h90;
    localparam int FMR_MULT_STOP_BIT = 7;
    localparam int FMR_PHASE_STOP_BIT = 6;
    localparam int FMR_PIN_HIZ_BIT = 5;
    localparam int FMR_RSVD_BIT = 4;
    localparam int FMR_FR_LSB = 0;
    localparam int FR_MULT_LSB = 2;
    localparam logic [1:0] FR_MULT_ONE = 2'h0;
    localparam logic [1:0] FR_MULT_TWO = 2'h1;

    // Power-on value of the register for each mode.
    localparam logic [DATA_W-1:0] FMR_INIT_M01 = 8'h00;
    localparam logic [DATA_W-1:0] FMR_INIT_M2 = 8'h40;
    localparam logic [DATA_W-1:0] FMR_INIT_M3 = 8'h60;
    localparam logic [DATA_W-1:0] FMR_INIT_M45 = 8'ha6;
    localparam logic [DATA_W-1:0] FMR_INIT_M6 = 8'he0;
    localparam logic [DATA_W-1:0] DATA_ZERO = 8'h00;

    function automatic logic [DATA_W-1:0] fmr_init(input logic [2:0] m);
        logic [DATA_W-1:0] v;
        v = FMR_INIT_M6;
        case (m)
            MODE0, MODE1: v = FMR_INIT_M01;
            MODE2: v = FMR_INIT_M2;
            MODE3: v = FMR_INIT_M3;
            MODE4, MODE5: v = FMR_INIT_M45;
            default: v = FMR_INIT_M6;
        endcase
        return v;
    endfunction

endpackage

// File: design/mode_cfg_if.sv
// Decoded clock mode attributes passed between controller and decoder.
`timescale 1ns/100ps
interface mode_cfg_if;
    import clk_mode_pkg::*;
    clock_mode_t mode;
    logic crystal_out_pin_sel;
    logic mult_avail;
    logic phase_avail;
    logic pin_is_input;
    logic pin_can_drive;
    phase_t shift;
    clk_src_t src;

    modport decoder (
        input mode, crystal_out_pin_sel,
        output mult_avail, phase_avail, pin_is_input, pin_can_drive,
        output shift, src
    );
    modport ctrl (
        output mode, crystal_out_pin_sel,
        input mult_avail, phase_avail, pin_is_input, pin_can_drive,
        input shift, src
    );
endinterface

// File: design/mode_decoder.sv
// Combinational decode of the held clock mode into its attributes.
`timescale 1ns/100ps
module mode_decoder (
    mode_cfg_if.decoder cfg
);
    import clk_mode_pkg::*;

    always_comb begin
        cfg.mult_avail = 1'b0;
        cfg.phase_avail = 1'b0;
        cfg.pin_is_input = 1'b0;
        cfg.pin_can_drive = 1'b0;
        cfg.shift = PH_NONE;
        cfg.src = cfg.crystal_out_pin_sel ? SRC_CRYSTAL_OUT_PIN : SRC_XIN_CLK;
        case (cfg.mode)
            MODE0: begin
                cfg.mult_avail = 1'b1;
                cfg.phase_avail = 1'b1;
                cfg.pin_can_drive = 1'b1;
                cfg.shift = PH_ALIGN;
            end
            MODE1: begin
                cfg.mult_avail = 1'b1;
                cfg.phase_avail = 1'b1;
                cfg.pin_can_drive = 1'b1;
                cfg.shift = PH_LEAD;
            end
            MODE2: begin
                cfg.mult_avail = 1'b1;
                cfg.pin_can_drive = 1'b1;
            end
            MODE3: begin
                cfg.mult_avail = 1'b1;
            end
            MODE4: begin
                cfg.phase_avail = 1'b1;
                cfg.pin_is_input = 1'b1;
                cfg.shift = PH_ALIGN;
                cfg.src = SRC_CLKIO;
            end
            MODE5: begin
                cfg.phase_avail = 1'b1;
                cfg.pin_is_input = 1'b1;
                cfg.shift = PH_LAG;
                cfg.src = SRC_CLKIO;
            end
            MODE6: begin
                cfg.pin_is_input = 1'b1;
                cfg.src = SRC_CLKIO;
            end
            default: begin
                cfg.src = SRC_OFF;
            end
        endcase
    end

endmodule // mode_decoder

// File: bench/clk_source_model.sv
// Behavioural clock source and pin load facing the clock mode controller.
`timescale 1ns/100ps
module clk_source_model (
    // Clock.
    input wire logic core_clk,
    // Source controls from the bench.
    input wire logic ext_drive,
    input wire logic ext_run,
    // Clock pin as seen by the device.
    input wire logic dev_out,
    input wire logic dev_oe_n,
    output logic pin_level
);
    logic ext_ff = 1'b0;
    logic float_ff = 1'b0;

    ////////////////////////////////////////////////////////////////////////
    // The source toggles each cycle and stands low while it is paused.
    always_ff @(posedge core_clk) begin
        if (!ext_run) begin
            ext_ff <= 1'b0;
        end else begin
            ext_ff <= ~ext_ff;
        end
    end

    // An undriven pin has no pull, so it shows a level that never settles.
    always_ff @(posedge core_clk) begin
        float_ff <= ~pin_level;
    end

    ////////////////////////////////////////////////////////////////////////
    // The source drives the pin only in the pin clock modes.
    always_comb begin
        if (!dev_oe_n) begin
            pin_level = dev_out;
        end else if (ext_drive) begin
            pin_level = ext_ff;
        end else begin
            pin_level = float_ff;
        end
    end
endmodule // clk_source_model

// File: bench/clock_mode_pll_select_tb.sv
// Self-checking bench for the clock mode controller.
`timescale 1ns/100ps
module clock_mode_pll_select_tb;
    import clk_mode_pkg::*;
    logic core_clk, nrst, dual_pin, ext_drive, ext_run, pin_in;
    logic [2:0] mode_pins;
    logic pin_out, pin_oe_n, reg_wr, reg_rd, osc_en, mult_run, phase_run;
    logic [ADDR_W-1:0] reg_addr;
    logic [DATA_W-1:0] reg_wdata, reg_rdata;
    clock_mode_t clock_mode;
    clk_src_t clock_source;
    mult_t mult_factor;
    phase_t phase_shift;
    logic internal_clk, pause_request, pause_acknowledge;
    int fails = 0;
    int cmp_count = 0;
    logic [7:0] wv [7] = '{8'he0, 8'h40, 8'h24, 8'h08, 8'h40, 8'h50, 8'h0f};
    logic [7:0] rv [7] = '{8'he0, 8'h40, 8'h64, 8'h68, 8'he0, 8'he0, 8'hef};

    clock_mode_pll_select DUT (
        .core_clk(core_clk), .nrst(nrst),
        .mode_select_bit2(mode_pins[2]), .mode_select_bit1(mode_pins[1]),
        .mode_select_bit0(mode_pins[0]),
        .pause_request_or_crystal_select(dual_pin),
        .clock_io_pin_in(pin_in), .clock_io_pin_out(pin_out),
        .clock_io_pin_oe_n(pin_oe_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .clock_mode(clock_mode),
        .crystal_osc_en(osc_en), .clock_source(clock_source),
        .mult_pll_run(mult_run), .phase_pll_run(phase_run),
        .mult_factor(mult_factor), .phase_shift(phase_shift),
        .internal_clk(internal_clk), .pause_request(pause_request),
        .pause_acknowledge(pause_acknowledge)
    );

    clk_source_model partner (
        .core_clk(core_clk), .ext_drive(ext_drive), .ext_run(ext_run),
        .dev_out(pin_out), .dev_oe_n(pin_oe_n), .pin_level(pin_in)
    );

    ////////////////////////////////////////////////////////////////////////
    initial begin
        core_clk = 1'b0;
        forever #50 core_clk = ~core_clk;
    end

    task automatic tally_and_finish();
        if (fails == 0 && cmp_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp) begin
            fails++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
        @(posedge core_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask

    task automatic reg_read(input logic [7:0] a, output logic [7:0] d);
        @(posedge core_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1;
        d = reg_rdata;
    endtask

    function automatic logic [7:0] init_fmr(input int m);
        case (m)
            0, 1: return 8'h00;
            2: return 8'h40;
            3: return 8'h60;
            4, 5: return 8'ha6;
            default: return 8'he0;
        endcase
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Holds reset three cycles with the straps applied, then releases it.
    task automatic do_reset(input int m, input logic xs);
        @(posedge core_clk);
        nrst <= 1'b0;
        mode_pins <= 3'(m);
        dual_pin <= xs;
        ext_drive <= (m >= 4);
        ext_run <= 1'b1;
        repeat (2) @(posedge core_clk);
        #1;
        chk(8'(pin_oe_n), 8'h01);
        @(posedge core_clk);
        nrst <= 1'b1;
        @(posedge core_clk);
        #1;
    endtask

    // Compares every status output except internal_clk, and the register, with the mode table.
    task automatic check_state(input int m, input logic xs,
                               input logic [7:0] fv);
        logic mr, pr;
        logic [7:0] d;
        phase_t ps;
        mult_t mf;
        clk_src_t src;
        mr = (m <= 3) && !fv[7];
        pr = (m == 0 || m == 1 || m == 4 || m == 5) && !fv[6];
        ps = !pr ? PH_NONE : m == 1 ? PH_LEAD : m == 5 ? PH_LAG : PH_ALIGN;
        mf = (mr && pr) ? MULT_X4 : !mr ? MULT_X1 :
             fv[3:2] == 2'h0 ? MULT_X1 : fv[3:2] == 2'h1 ? MULT_X2 : MULT_X4;
        src = m >= 4 ? SRC_CLKIO : xs ? SRC_CRYSTAL_OUT_PIN : SRC_XIN_CLK;
        chk(8'(clock_mode), 8'(m));
        chk(8'(osc_en), 8'((m <= 3) && xs));
        chk(8'(clock_source), 8'(src));
        chk(8'(mult_run), 8'(mr));
        chk(8'(phase_run), 8'(pr));
        chk(8'(phase_shift), 8'(ps));
        chk(8'(mult_factor), 8'(mf));
        chk(8'(pin_oe_n), 8'(fv[5]));
        reg_read(FMR_ADDR, d);
        chk(d, fv);
    endtask

    // Watches the clock pin and the pause link for a few cycles.
    task automatic activity(input int m);
        logic p;
        if (m <= 2) begin
            p = pin_out;
            repeat (4) begin
                @(posedge core_clk);
                #1;
                chk(8'(pin_out), 8'(!p));
                p = pin_out;
            end
        end else if (m >= 4) begin
            repeat (4) begin
                p = pin_in;
                @(posedge core_clk);
                #1;
                chk(8'(internal_clk), 8'(p));
            end
            @(posedge core_clk);
            dual_pin <= 1'b1;
            ext_run <= 1'b0;
            @(posedge core_clk);
            #1;
            chk(8'(pause_request), 8'h01);
            @(posedge core_clk);
            #1;
            chk(8'(pause_acknowledge), 8'h01);
            @(posedge core_clk);
            dual_pin <= 1'b0;
            ext_run <= 1'b1;
        end else begin
            @(posedge core_clk);
            dual_pin <= ~dual_pin;
            repeat (2) @(posedge core_clk);
            #1;
            chk(8'(pause_request), 8'h00);
            chk(8'(pin_oe_n), 8'h01);
        end
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial begin
        logic [7:0] d;
        nrst = 1'b0;
        mode_pins = 3'h0;
        dual_pin = 1'b0;
        ext_drive = 1'b0;
        ext_run = 1'b1;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        for (int m = 0; m <= 6; m++) begin
            for (int xs = 0; xs <= ((m <= 3) ? 1 : 0); xs++) begin
                do_reset(m, xs[0]);
                check_state(m, xs[0], init_fmr(m));
                if (m == 0) begin
                    reg_write(8'h91, 8'hff);
                    reg_read(8'h91, d);
                    chk(d, 8'h00);
                    reg_read(FMR_ADDR, d);
                    chk(d, 8'h00);
                end
                activity(m);
                reg_write(FMR_ADDR, wv[m]);
                @(posedge core_clk);
                #1;
                check_state(m, xs[0], rv[m]);
            end
        end
        @(posedge core_clk);
        mode_pins <= 3'h0;
        repeat (3) @(posedge core_clk);
        #1;
        chk(8'(clock_mode), 8'h06);
        tally_and_finish();
    end

    initial begin
        repeat (20000) @(posedge core_clk);
        fails++;
        tally_and_finish();
    end
endmodule // clock_mode_pll_select_tb
